// *** regulator_drive_pkg.sv ***
package regulator_drive_pkg;

  // Clock and timing figures
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned OCP_DEG_NS = 5000;
  localparam int unsigned OCP_DEG_CYC = (OCP_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_RST_NS = 2000;
  localparam int unsigned SLEEP_RST_CYC = (SLEEP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned IN_DEG_NS = 200;
  localparam int unsigned IN_DEG_CYC = (IN_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_US = 4000;
  localparam int unsigned RETRY_CYC_DFLT = RETRY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RETRY_W = 17;
  localparam int unsigned DLY_STEP_NS = 200;
  localparam int unsigned DLY_STEP_CYC = DLY_STEP_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;

  // Control field positions
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned CTRL_CL_BIT = 1;
  localparam int unsigned CTRL_VSEL_LSB = 2;
  localparam int unsigned CTRL_SEQ_DIS_BIT = 4;
  localparam int unsigned CTRL_SLEW_LSB = 5;
  localparam int unsigned CTRL_DCMP_BIT = 7;
  localparam int unsigned CTRL_TGT_LSB = 8;
  localparam int unsigned CTRL_CLR_BIT = 12;

  // Reset values
  localparam logic [1:0] VSEL_RST = 2'h0;
  localparam logic [1:0] SLEW_RST = 2'h0;
  localparam logic [3:0] TARGET_RST = 4'hF;
  localparam logic [2:0] INT_MASK_RST = 3'h0;

  // Output-voltage codes: 3.3 V, 5 V, 4 V, 5.7 V
  localparam logic [1:0] VSEL_3V3 = 2'h0;
  localparam logic [1:0] VSEL_5V0 = 2'h1;
  localparam logic [1:0] VSEL_4V0 = 2'h2;
  localparam logic [1:0] VSEL_5V7 = 2'h3;

  // Interrupt status bits
  localparam int unsigned IRQ_UV_BIT = 0;
  localparam int unsigned IRQ_OC_BIT = 1;
  localparam int unsigned IRQ_RETRY_BIT = 2;

  typedef struct packed {
    logic [3:0] delay_target;
    logic delay_comp_enable;
    logic [1:0] slew;
    logic supply_sequencing_disable;
    logic [1:0] vsel;
    logic regulator_current_limit_sel;
    logic regulator_disable;
  } ctrl_type;

  typedef enum logic [2:0] {
    OC_RUN = 3'b001,
    OC_FILTER = 3'b010,
    OC_RETRY = 3'b100
  } oc_state_type;

endpackage

// *** regulator_drive_ctrl.sv ***
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
module regulator_drive_ctrl
  import regulator_drive_pkg::*;
#(
  parameter int unsigned RETRY_CYC = RETRY_CYC_DFLT
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_variant_i,
  input wire logic sleep_n_i,
  input wire logic regulator_undervolt_i,
  input wire logic regulator_overcurrent_i,
  input wire logic regulator_below_ref_i,
  input wire logic regulator_current_limit_i,
  input wire logic [1:0] regulator_voltage_pin_i,
  input wire logic [1:0] slew_pin_i,
  input wire logic [2:0] drive_high_i,
  input wire logic [2:0] drive_low_i,
  input wire logic [2:0] hs_gate_off_i,
  input wire logic [2:0] ls_gate_off_i,
  output logic fault_out_n_o,
  output logic fault_out_n_oe_n_o,
  output logic regulator_hs_on_o,
  output logic regulator_ls_on_o,
  output logic regulator_low_limit_o,
  output logic [1:0] regulator_vsel_o,
  output logic ldo_from_regulator_o,
  output logic charge_pump_en_o,
  output logic [1:0] slew_o,
  output logic [2:0] gate_hs_o,
  output logic [2:0] gate_ls_o,
  output logic irq_o
);

  localparam int unsigned SYNC_W = 22;

  logic [SYNC_W-1:0] sync_meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic sleep_n_s, uv_s, oc_s, below_s, cl_s, strap_s;
  logic [1:0] vpin_s, slewpin_s;
  logic [2:0] inh_s, inl_s, hs_off_s, ls_off_s;
  logic strap_done_r, serial_r;
  logic [1:0] strap_wait_r;
  ctrl_type ctrl_r;
  logic clear_fault_cmd_r;
  logic [2:0] int_status_r, int_mask_r, int_set;
  logic regulator_undervolt_flag_r, regulator_overcurrent_flag_r;
  logic uv_prev_r, oc_event, retry_done;
  oc_state_type oc_state_r;
  logic [RETRY_W-1:0] oc_cnt_r;
  logic [7:0] sleep_cnt_r;
  logic sleep_pulse_clr;
  logic wr_en, rd_en;
  logic reg_enabled, reg_halt;
  logic [7:0] pd_meas [3];

  // Two-flop synchroniser for every pin input
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en_i) begin
      sync_meta_r <= {strap_s_in(), sleep_n_i, regulator_undervolt_i, regulator_overcurrent_i,
                      regulator_below_ref_i, regulator_current_limit_i,
                      regulator_voltage_pin_i, slew_pin_i, drive_high_i, drive_low_i,
                      hs_gate_off_i, ls_gate_off_i};
      sync_r <= sync_meta_r;
    end
  end

  function automatic logic strap_s_in();
    return serial_variant_i;
  endfunction

  assign {strap_s, sleep_n_s, uv_s, oc_s, below_s, cl_s, vpin_s, slewpin_s,
          inh_s, inl_s, hs_off_s, ls_off_s} = sync_r;

  // Variant strap caught once the synchroniser holds the real pin level
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_r <= 1'b0;
      strap_wait_r <= 2'h0;
      serial_r <= 1'b0;
    end else if (clk_en_i && !strap_done_r) begin
      if (strap_wait_r != 2'h2) begin
        strap_wait_r <= strap_wait_r + 2'h1; // Reset zeros still in the flops
      end else begin
        strap_done_r <= 1'b1;
        serial_r <= strap_s;
      end
    end
  end

  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  // Control register and self-clearing fault clear command
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= '{delay_target: TARGET_RST, slew: SLEW_RST, vsel: VSEL_RST, default: 1'b0};
      clear_fault_cmd_r <= 1'b0;
    end else if (clk_en_i) begin
      clear_fault_cmd_r <= 1'b0;
      if (wr_en && paddr_i == CTRL_OFS) begin
        ctrl_r <= pwdata_i[CTRL_TGT_LSB+3:0];
        clear_fault_cmd_r <= pwdata_i[CTRL_CLR_BIT];
      end
    end
  end

  // Interrupt mask and write-one-to-clear status, set wins
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_status_r <= '0;
      int_mask_r <= INT_MASK_RST;
    end else if (clk_en_i) begin
      if (wr_en && paddr_i == INT_MASK_OFS) begin
        int_mask_r <= pwdata_i[2:0];
      end
      if (wr_en && paddr_i == INT_STATUS_OFS) begin
        int_status_r <= (int_status_r & ~pwdata_i[2:0]) | int_set;
      end else begin
        int_status_r <= int_status_r | int_set;
      end
    end
  end

  // APB answer: read data registered in setup, pready in access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= psel_i && !penable_i;
      if (psel_i && !penable_i) begin
        pslverr_o <= !(paddr_i == CTRL_OFS || paddr_i == STATUS_OFS ||
                       paddr_i == INT_STATUS_OFS || paddr_i == INT_MASK_OFS);
      end
      prdata_o <= '0;
      if (rd_en) begin
        case (paddr_i)
          CTRL_OFS: prdata_o <= {19'h0, clear_fault_cmd_r, ctrl_r};
          STATUS_OFS: prdata_o <= {16'h0, pd_meas[0], 1'b0, ldo_from_regulator_o, serial_r,
                                   !fault_out_n_oe_n_o, regulator_overcurrent_flag_r,
                                   regulator_undervolt_flag_r, reg_halt_flags(),
                                   reg_halt_flags()};
          INT_STATUS_OFS: prdata_o <= {29'h0, int_status_r};
          INT_MASK_OFS: prdata_o <= {29'h0, int_mask_r};
          default: prdata_o <= '0;
        endcase
      end
    end
  end

  // Global fault and regulator fault summary follow the latched flags
  function automatic logic reg_halt_flags();
    return regulator_undervolt_flag_r | regulator_overcurrent_flag_r;
  endfunction

  // Sleep pin held low long enough counts as a reset pulse
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_cnt_r <= '0;
    end else if (clk_en_i) begin
      if (sleep_n_s) begin
        sleep_cnt_r <= '0;
      end else if (sleep_cnt_r != 8'(SLEEP_RST_CYC)) begin
        sleep_cnt_r <= sleep_cnt_r + 8'h01;
      end
    end
  end

  assign sleep_pulse_clr = sleep_n_s && (sleep_cnt_r == 8'(SLEEP_RST_CYC));

  // Undervoltage flag: set on condition, cleared by command or sleep pulse
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_undervolt_flag_r <= 1'b0;
      uv_prev_r <= 1'b0;
    end else if (clk_en_i) begin
      uv_prev_r <= uv_s;
      if (uv_s) begin
        regulator_undervolt_flag_r <= 1'b1;
      end else if (clear_fault_cmd_r || sleep_pulse_clr) begin
        regulator_undervolt_flag_r <= 1'b0;
      end
    end
  end

  assign oc_event = (oc_state_r == OC_FILTER) && oc_s && (oc_cnt_r >= RETRY_W'(OCP_DEG_CYC));
  assign retry_done = (oc_state_r == OC_RETRY) && (oc_cnt_r >= RETRY_W'(RETRY_CYC - 1));
  assign int_set = {retry_done, oc_event, uv_s && !uv_prev_r};

  // Overcurrent deglitch, latch and automatic retry
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_state_r <= OC_RUN;
      oc_cnt_r <= '0;
      regulator_overcurrent_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      case (oc_state_r)
        OC_RUN: begin
          oc_cnt_r <= '0;
          if (oc_s) begin
            oc_state_r <= OC_FILTER;
          end
        end
        OC_FILTER: begin
          oc_cnt_r <= oc_cnt_r + RETRY_W'(1);
          if (!oc_s) begin
            oc_state_r <= OC_RUN;
          end else if (oc_event) begin
            oc_state_r <= OC_RETRY;
            oc_cnt_r <= '0;
            regulator_overcurrent_flag_r <= 1'b1;
          end
        end
        OC_RETRY: begin
          oc_cnt_r <= oc_cnt_r + RETRY_W'(1);
          if (retry_done) begin
            oc_state_r <= OC_RUN;
            regulator_overcurrent_flag_r <= 1'b0;
          end
        end
        default: oc_state_r <= OC_RUN;
      endcase
    end
  end

  assign reg_enabled = !(serial_r && ctrl_r.regulator_disable);
  assign reg_halt = uv_s || (oc_state_r == OC_RETRY) || oc_event;

  // Regulator switches and static settings
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulator_hs_on_o <= 1'b0;
      regulator_ls_on_o <= 1'b0;
      regulator_low_limit_o <= 1'b0;
      regulator_vsel_o <= VSEL_RST;
      ldo_from_regulator_o <= 1'b0;
      charge_pump_en_o <= 1'b0;
      slew_o <= SLEW_RST;
    end else if (clk_en_i) begin
      regulator_hs_on_o <= reg_enabled && !reg_halt && below_s && !cl_s;
      regulator_ls_on_o <= reg_enabled && !reg_halt && !below_s;
      regulator_low_limit_o <= serial_r && ctrl_r.regulator_current_limit_sel;
      regulator_vsel_o <= serial_r ? ctrl_r.vsel : vpin_s;
      ldo_from_regulator_o <= reg_enabled && !uv_s &&
                              !(serial_r && ctrl_r.supply_sequencing_disable) &&
                              (regulator_vsel_o == VSEL_5V0 ||
                               regulator_vsel_o == VSEL_5V7);
      charge_pump_en_o <= sleep_n_s;
      slew_o <= serial_r ? ctrl_r.slew : slewpin_s;
    end
  end

  // Open-drain fault pin and interrupt line
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_out_n_o <= 1'b0;
      fault_out_n_oe_n_o <= 1'b1;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      fault_out_n_o <= 1'b0;
      fault_out_n_oe_n_o <= !(reg_halt || regulator_overcurrent_flag_r);
      irq_o <= |(int_status_r & ~int_mask_r); // Mask bit set hides its event
    end
  end

  // Per half-bridge deglitch, delay compensation and dead-time interlock
  for (genvar ph = 0; ph < 3; ph++) begin : g_phase
    logic [1:0] raw_cmd, filt_r, pend_r;
    logic [2:0] stab_r;
    logic [6:0] dly_cnt_r;
    logic [7:0] meas_cnt_r, pd_r;
    logic meas_on_r;
    logic [6:0] target_cyc, var_cyc;
    logic hs_want, ls_want;

    // 6x mode: high alone drives high side, low alone drives low side
    assign raw_cmd = {inh_s[ph] && !inl_s[ph], inl_s[ph] && !inh_s[ph]};
    assign target_cyc = 7'((ctrl_r.delay_target + 5'h01) * DLY_STEP_CYC);
    assign var_cyc = (pd_r[7] || pd_r[6:0] >= target_cyc) ? 7'h00 : target_cyc - pd_r[6:0];
    assign pd_meas[ph] = pd_r;

    // Command must hold still before it is believed
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        stab_r <= '0;
        filt_r <= '0;
      end else if (clk_en_i) begin
        if (raw_cmd != pend_r) begin
          stab_r <= '0;
        end else if (stab_r != 3'(IN_DEG_CYC)) begin
          stab_r <= stab_r + 3'h1;
        end else begin
          filt_r <= pend_r;
        end
      end
    end

    // Raw command seen last cycle, and padding delay counter
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pend_r <= '0;
        dly_cnt_r <= '0;
      end else if (clk_en_i) begin
        pend_r <= raw_cmd;
        if (filt_r != {hs_want, ls_want} || {gate_hs_o[ph], gate_ls_o[ph]} == filt_r) begin
          dly_cnt_r <= '0;
        end else if (dly_cnt_r != 7'h7F) begin
          dly_cnt_r <= dly_cnt_r + 7'h01;
        end
      end
    end

    assign {hs_want, ls_want} = filt_r;

    // Gate outputs with interlock against the opposite gate
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        gate_hs_o[ph] <= 1'b0;
        gate_ls_o[ph] <= 1'b0;
      end else if (clk_en_i) begin
        if (!serial_r || !ctrl_r.delay_comp_enable || dly_cnt_r >= var_cyc) begin
          gate_hs_o[ph] <= hs_want && ls_off_s[ph] && !gate_ls_o[ph];
          gate_ls_o[ph] <= ls_want && hs_off_s[ph] && !gate_hs_o[ph];
        end
        if (!hs_want) begin
          gate_hs_o[ph] <= 1'b0;
        end
        if (!ls_want) begin
          gate_ls_o[ph] <= 1'b0;
        end
      end
    end

    // Measure cycles from gate command to sensed gate voltage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meas_on_r <= 1'b0;
        meas_cnt_r <= '0;
        pd_r <= '0;
      end else if (clk_en_i) begin
        if (!meas_on_r && gate_hs_o[ph] == hs_off_s[ph]) begin
          meas_on_r <= 1'b1;
          meas_cnt_r <= 8'h01;
        end else if (meas_on_r && gate_hs_o[ph] != hs_off_s[ph]) begin
          meas_on_r <= 1'b0;
          pd_r <= meas_cnt_r;
        end else if (meas_on_r && meas_cnt_r != 8'hFF) begin
          meas_cnt_r <= meas_cnt_r + 8'h01;
        end
      end
    end
  end

endmodule

// *** regulator_drive_monitor.sv ***
`timescale 1ns/100ps
// Port-level checks of the regulator and drive control block
module regulator_drive_monitor
  import regulator_drive_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic serial_variant_i,
  input wire logic sleep_n_i,
  input wire logic regulator_undervolt_i,
  input wire logic [1:0] regulator_voltage_pin_i,
  input wire logic [1:0] slew_pin_i,
  input wire logic pready_o,
  input wire logic fault_out_n_oe_n_o,
  input wire logic regulator_hs_on_o,
  input wire logic regulator_ls_on_o,
  input wire logic regulator_low_limit_o,
  input wire logic [1:0] regulator_vsel_o,
  input wire logic ldo_from_regulator_o,
  input wire logic charge_pump_en_o,
  input wire logic [1:0] slew_o,
  input wire logic [2:0] gate_hs_o,
  input wire logic [2:0] gate_ls_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Bus answer timing: zero wait states, one-cycle ready
  a_apb_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  // Undervolt stops both switches and pulls the pin low
  a_uv_stops_switch: assert property (regulator_undervolt_i [*5] |-> !fault_out_n_oe_n_o &&
    !regulator_hs_on_o && !regulator_ls_on_o) else $error("undervolt not acted on");
  // Sleep stops the charge pump
  a_sleep_pump_off: assert property (!sleep_n_i [*5] |-> !charge_pump_en_o)
    else $error("charge pump runs in sleep");
  // No half-bridge has both gates on
  a_gate_no_overlap: assert property ((gate_hs_o & gate_ls_o) == 3'h0)
    else $error("gate overlap");
  // Pin variant follows its pins and keeps the high current limit
  a_pin_slew_follow: assert property ((!serial_variant_i && $stable(slew_pin_i)) [*8] |->
    slew_o == slew_pin_i) else $error("slew not from pin");
  a_pin_vsel_follow: assert property ((!serial_variant_i &&
    $stable(regulator_voltage_pin_i)) [*8] |-> regulator_vsel_o == regulator_voltage_pin_i)
    else $error("voltage not from pin");
  a_pin_limit_high: assert property (!serial_variant_i [*8] |-> !regulator_low_limit_o)
    else $error("low limit on pin variant");
  a_pin_ldo_switch: assert property ((!serial_variant_i && $stable(regulator_vsel_o)) [*5] |->
    ldo_from_regulator_o == regulator_vsel_o[0]) else $error("linear supply source wrong");

  // Main scenarios reached
  c_uv_seen: cover property (regulator_undervolt_i [*5]);
  c_fault_fall: cover property ($fell(fault_out_n_oe_n_o));
  c_low_gate_on: cover property ($rose(gate_ls_o[0]));
endmodule

// *** fault_pullup_model.sv ***
`timescale 1ns/100ps
// Controller-side fault line with its external pull-up
module fault_pullup_model (
  input wire logic pin_data_i,
  input wire logic pin_oe_n_i,
  output logic fault_line_o
);
  // Line sits high unless the device sinks it
  assign fault_line_o = pin_oe_n_i ? 1'b1 : pin_data_i;
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
bind regulator_drive_ctrl regulator_drive_monitor u_regulator_drive_monitor (.ref_clk_i,
  .rst_n_i, .psel_i, .penable_i, .serial_variant_i, .sleep_n_i, .regulator_undervolt_i,
  .regulator_voltage_pin_i, .slew_pin_i, .pready_o, .fault_out_n_oe_n_o, .regulator_hs_on_o,
  .regulator_ls_on_o, .regulator_low_limit_o, .regulator_vsel_o, .ldo_from_regulator_o,
  .charge_pump_en_o, .slew_o, .gate_hs_o, .gate_ls_o);
module tb;
  import regulator_drive_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, clk_en_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic serial_variant_i = 1, sleep_n_i = 1, regulator_undervolt_i = 0;
  logic regulator_overcurrent_i = 0, regulator_below_ref_i = 1, regulator_current_limit_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic [1:0] regulator_voltage_pin_i = 2'h0, slew_pin_i = 2'h1, regulator_vsel_o, slew_o;
  logic [2:0] drive_high_i = 3'h0, drive_low_i = 3'h0, hs_gate_off_i = 3'h7;
  logic [2:0] ls_gate_off_i = 3'h7, gate_hs_o, gate_ls_o;
  logic pready_o, pslverr_o, fault_out_n_o, fault_out_n_oe_n_o, regulator_hs_on_o, e, seen;
  logic regulator_ls_on_o, regulator_low_limit_o, ldo_from_regulator_o, charge_pump_en_o, irq_o;
  logic fault_line;
  int miscompares = 0, cmp_count = 0, tick = 0;

  regulator_drive_ctrl #(.RETRY_CYC(50)) u_regulator_drive_ctrl (.ref_clk_i, .rst_n_i,
    .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .serial_variant_i, .sleep_n_i, .regulator_undervolt_i, .regulator_overcurrent_i,
    .regulator_below_ref_i, .regulator_current_limit_i, .regulator_voltage_pin_i, .slew_pin_i,
    .drive_high_i, .drive_low_i, .hs_gate_off_i, .ls_gate_off_i, .fault_out_n_o,
    .fault_out_n_oe_n_o, .regulator_hs_on_o, .regulator_ls_on_o, .regulator_low_limit_o,
    .regulator_vsel_o, .ldo_from_regulator_o, .charge_pump_en_o, .slew_o, .gate_hs_o,
    .gate_ls_o, .irq_o);
  fault_pullup_model u_fault_pullup_model (.pin_data_i(fault_out_n_o),
    .pin_oe_n_i(fault_out_n_oe_n_o), .fault_line_o(fault_line));

  // Clock, hang limit and high-side gate watcher
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    tick <= tick + 1;
    if (gate_hs_o[0]) seen <= 1'b1;
    if (tick == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic do_reset(input logic serial);
    rst_n_i <= 1'b0;
    serial_variant_i <= serial;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(3);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset(1'b1);
    apb(0, CTRL_OFS, 32'h0);
    chk(q, 32'h00000F00);
    apb(0, 8'h10, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("test reset done");
    apb(1, CTRL_OFS, 32'h000005EE);
    cyc(6);
    chk({24'h0, regulator_vsel_o, slew_o, regulator_low_limit_o, ldo_from_regulator_o,
      regulator_hs_on_o, charge_pump_en_o}, 32'hFF);
    regulator_current_limit_i <= 1'b1;
    cyc(5);
    chk({31'h0, regulator_hs_on_o}, 32'h0);
    regulator_current_limit_i <= 1'b0;
    apb(1, CTRL_OFS, 32'h000005FF);
    cyc(6);
    chk({30'h0, ldo_from_regulator_o, regulator_hs_on_o}, 32'h0);
    apb(1, CTRL_OFS, 32'h000005EE);
    $display("test config done");
    regulator_undervolt_i <= 1'b1;
    cyc(6);
    chk({30'h0, fault_line, regulator_hs_on_o}, 32'h0);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'h3F, 32'h37);
    regulator_undervolt_i <= 1'b0;
    cyc(6);
    chk({30'h0, fault_line, regulator_hs_on_o}, 32'h3);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'h3F, 32'h27);
    chk({31'h0, irq_o}, 32'h1);
    apb(1, INT_MASK_OFS, 32'h1);
    cyc(2);
    chk({31'h0, irq_o}, 32'h0);
    apb(1, INT_MASK_OFS, 32'h0);
    apb(1, INT_STATUS_OFS, 32'h1);
    cyc(2);
    chk({31'h0, irq_o}, 32'h0);
    apb(1, CTRL_OFS, 32'h000015EE);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'h3F, 32'h20);
    apb(0, CTRL_OFS, 32'h0);
    chk(q, 32'h000005EE);
    $display("test undervolt done");
    regulator_overcurrent_i <= 1'b1;
    cyc(100);
    regulator_overcurrent_i <= 1'b0;
    cyc(5);
    chk({31'h0, fault_line}, 32'h1);
    regulator_overcurrent_i <= 1'b1;
    cyc(140);
    chk({30'h0, fault_line, regulator_hs_on_o}, 32'h0);
    regulator_overcurrent_i <= 1'b0;
    cyc(10);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'h3F, 32'h3B);
    cyc(60);
    chk({30'h0, fault_line, regulator_hs_on_o}, 32'h3);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'h3F, 32'h20);
    apb(0, INT_STATUS_OFS, 32'h0);
    chk(q, 32'h6);
    apb(1, INT_STATUS_OFS, 32'h7);
    $display("test overcurrent done");
    regulator_undervolt_i <= 1'b1;
    cyc(6);
    regulator_undervolt_i <= 1'b0;
    sleep_n_i <= 1'b0;
    cyc(60);
    chk({31'h0, charge_pump_en_o}, 32'h0);
    sleep_n_i <= 1'b1;
    cyc(6);
    apb(0, STATUS_OFS, 32'h0);
    chk(q & 32'hF, 32'h0);
    $display("test sleep done");
    seen = 1'b0;
    drive_high_i <= 3'h1;
    cyc(2);
    drive_high_i <= 3'h0;
    cyc(100);
    chk({31'h0, seen}, 32'h0);
    drive_high_i <= 3'h1;
    cyc(100);
    chk({26'h0, gate_hs_o, gate_ls_o}, 32'h8);
    hs_gate_off_i <= 3'h6;
    drive_high_i <= 3'h0;
    drive_low_i <= 3'h1;
    cyc(40);
    chk({29'h0, gate_ls_o}, 32'h0);
    hs_gate_off_i <= 3'h7;
    cyc(100);
    chk({29'h0, gate_ls_o}, 32'h1);
    drive_low_i <= 3'h0;
    $display("test gates done");
    do_reset(1'b0);
    for (int c = 0; c < 4; c++) begin
      regulator_voltage_pin_i <= 2'(c);
      cyc(8);
      chk({26'h0, regulator_vsel_o, slew_o, regulator_low_limit_o, ldo_from_regulator_o},
        {26'h0, 2'(c), 2'h1, 1'b0, c[0]});
    end
    apb(1, CTRL_OFS, 32'h1);
    cyc(6);
    chk({31'h0, regulator_hs_on_o}, 32'h1);
    $display("test pin variant done");
    stop_test();
  end
endmodule
